// [rtl/pjiu_pkg.sv]
/*
 * constants shared by the test access port instruction unit: opcodes, capture
 * pattern layout, reset values and the reconfiguration pulse timing.
 * assumes a system clock of 40 MHz and a test clock from the outside host.
 */
package pjiu_pkg;

    localparam int unsigned IR_W            = 8;
    localparam int unsigned DR_W            = 32;

    // instruction codes
    localparam logic [7:0]  OP_EXTEST       = 8'h00;
    localparam logic [7:0]  OP_SAMPLE       = 8'h01;
    localparam logic [7:0]  OP_CLAMP        = 8'hfa;
    localparam logic [7:0]  OP_HIGHZ        = 8'hfc;
    localparam logic [7:0]  OP_USERCODE     = 8'hfd;
    localparam logic [7:0]  OP_IDCODE       = 8'hfe;
    localparam logic [7:0]  OP_BYPASS       = 8'hff;
    localparam logic [7:0]  OP_RELOAD       = 8'hee;

    // capture pattern layout
    localparam int unsigned CAP_ISP_BIT     = 4;
    localparam int unsigned CAP_PROT_BIT    = 3;
    localparam logic [7:0]  CAP_FIXED       = 8'h01;

    // values after reset
    localparam logic [7:0]  IR_RESET        = OP_IDCODE;
    localparam logic [31:0] USERCODE_BLANK  = 32'hffffffff;

    // reconfiguration pulse: least time rounded up to whole cycles
    localparam int unsigned SYS_PERIOD_NS   = 25;
    localparam int unsigned PULSE_MIN_NS    = 300;
    localparam int unsigned PULSE_MAX_NS    = 500;
    localparam int unsigned PULSE_CYC       = (PULSE_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int unsigned PULSE_CNT_W     = 5;

    // tap controller states
    typedef enum logic [3:0] {
        PJIU_TLR    = 4'h0,
        PJIU_RTI    = 4'h1,
        PJIU_SELDR  = 4'h2,
        PJIU_CAPDR  = 4'h3,
        PJIU_SHDR   = 4'h4,
        PJIU_EX1DR  = 4'h5,
        PJIU_PAUDR  = 4'h6,
        PJIU_EX2DR  = 4'h7,
        PJIU_UPDR   = 4'h8,
        PJIU_SELIR  = 4'h9,
        PJIU_CAPIR  = 4'ha,
        PJIU_SHIR   = 4'hb,
        PJIU_EX1IR  = 4'hc,
        PJIU_PAUIR  = 4'hd,
        PJIU_EX2IR  = 4'he,
        PJIU_UPIR   = 4'hf
    } pjiu_state_t;

endpackage

// [rtl/pjiu_tap_if.sv]
/*
 * carrier between the tap controller and the instruction logic.
 * assumes both ends run on the test clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface pjiu_tap_if;
    pjiu_pkg::pjiu_state_t state;
    logic                  tlr;
    logic                  capture_ir;
    logic                  shift_ir;
    logic                  update_ir;
    logic                  capture_dr;
    logic                  shift_dr;
    logic                  update_dr;

    modport ctrl (output state, tlr, capture_ir, shift_ir, update_ir,
                  capture_dr, shift_dr, update_dr);
    modport user (input state, tlr, capture_ir, shift_ir, update_ir,
                  capture_dr, shift_dr, update_dr);
endinterface
`default_nettype wire

// [rtl/pjiu_sync.sv]
/*
 * three-stage synchroniser; the output follows once stages two and three agree.
 * assumes the input is a level or a toggle from another clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module pjiu_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] q_d;

    // bits already agreeing in the last two stages are passed on
    assign q_d = (s2_q & s3_q) | (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & q);

    // synchroniser chain and filtered output
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            q    <= '0;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            q    <= q_d;
        end
    end
endmodule
`default_nettype wire

// [rtl/pjiu_tap_fsm.sv]
/*
 * sixteen-state test access port controller, stepping on the rising test clock.
 * assumes mode select is valid around rising edges of the test clock.
 */
`timescale 1ns/1ps
`default_nettype none
module pjiu_tap_fsm (
    input  wire logic  tck,
    input  wire logic  resetn,
    input  wire logic  tms,
    pjiu_tap_if.ctrl   tap
);
    pjiu_pkg::pjiu_state_t st_q;
    pjiu_pkg::pjiu_state_t st_d;

    // next state from mode select
    always_comb begin
        case (st_q)
            pjiu_pkg::PJIU_TLR:   st_d = tms ? pjiu_pkg::PJIU_TLR   : pjiu_pkg::PJIU_RTI;
            pjiu_pkg::PJIU_RTI:   st_d = tms ? pjiu_pkg::PJIU_SELDR : pjiu_pkg::PJIU_RTI;
            pjiu_pkg::PJIU_SELDR: st_d = tms ? pjiu_pkg::PJIU_SELIR : pjiu_pkg::PJIU_CAPDR;
            pjiu_pkg::PJIU_CAPDR: st_d = tms ? pjiu_pkg::PJIU_EX1DR : pjiu_pkg::PJIU_SHDR;
            pjiu_pkg::PJIU_SHDR:  st_d = tms ? pjiu_pkg::PJIU_EX1DR : pjiu_pkg::PJIU_SHDR;
            pjiu_pkg::PJIU_EX1DR: st_d = tms ? pjiu_pkg::PJIU_UPDR  : pjiu_pkg::PJIU_PAUDR;
            pjiu_pkg::PJIU_PAUDR: st_d = tms ? pjiu_pkg::PJIU_EX2DR : pjiu_pkg::PJIU_PAUDR;
            pjiu_pkg::PJIU_EX2DR: st_d = tms ? pjiu_pkg::PJIU_UPDR  : pjiu_pkg::PJIU_SHDR;
            pjiu_pkg::PJIU_UPDR:  st_d = tms ? pjiu_pkg::PJIU_SELDR : pjiu_pkg::PJIU_RTI;
            pjiu_pkg::PJIU_SELIR: st_d = tms ? pjiu_pkg::PJIU_TLR   : pjiu_pkg::PJIU_CAPIR;
            pjiu_pkg::PJIU_CAPIR: st_d = tms ? pjiu_pkg::PJIU_EX1IR : pjiu_pkg::PJIU_SHIR;
            pjiu_pkg::PJIU_SHIR:  st_d = tms ? pjiu_pkg::PJIU_EX1IR : pjiu_pkg::PJIU_SHIR;
            pjiu_pkg::PJIU_EX1IR: st_d = tms ? pjiu_pkg::PJIU_UPIR  : pjiu_pkg::PJIU_PAUIR;
            pjiu_pkg::PJIU_PAUIR: st_d = tms ? pjiu_pkg::PJIU_EX2IR : pjiu_pkg::PJIU_PAUIR;
            pjiu_pkg::PJIU_EX2IR: st_d = tms ? pjiu_pkg::PJIU_UPIR  : pjiu_pkg::PJIU_SHIR;
            pjiu_pkg::PJIU_UPIR:  st_d = tms ? pjiu_pkg::PJIU_SELDR : pjiu_pkg::PJIU_RTI;
            default:              st_d = pjiu_pkg::PJIU_TLR;
        endcase
    end

    // state register
    always_ff @(posedge tck or negedge resetn) begin
        if (!resetn) begin
            st_q <= pjiu_pkg::PJIU_TLR;
        end else begin
            st_q <= st_d;
        end
    end

    // state decodes
    assign tap.state      = st_q;
    assign tap.tlr        = (st_q == pjiu_pkg::PJIU_TLR);
    assign tap.capture_ir = (st_q == pjiu_pkg::PJIU_CAPIR);
    assign tap.shift_ir   = (st_q == pjiu_pkg::PJIU_SHIR);
    assign tap.update_ir  = (st_q == pjiu_pkg::PJIU_UPIR);
    assign tap.capture_dr = (st_q == pjiu_pkg::PJIU_CAPDR);
    assign tap.shift_dr   = (st_q == pjiu_pkg::PJIU_SHDR);
    assign tap.update_dr  = (st_q == pjiu_pkg::PJIU_UPDR);
endmodule
`default_nettype wire

// [rtl/pjiu_top.sv]
/*
 * instruction unit of the test access port: instruction register with status
 * capture, instruction decode, identification registers, read protection and
 * the reconfiguration pulse.
 * assumes a programming engine on clk_sys reports programming mode and the
 * protection events, and an outer boundary-scan chain hangs on bsr_* ports.
 */
`timescale 1ns/1ps
`default_nettype none
module pjiu_top #(
    parameter logic [31:0] ID_VALUE = 32'h0a5c0001  // arbitrary identity value
) (
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic        tck,
    input  wire logic        tms,
    input  wire logic        tdi,
    output logic             tdo,
    output logic             tdo_oe,
    input  wire logic [31:0] usercode_val,
    input  wire logic        isp_mode_in,
    input  wire logic        protect_set,
    input  wire logic        erase_all,
    input  wire logic        bsr_tdo,
    output logic             bsr_select,
    output logic             bsr_capture,
    output logic             bsr_shift,
    output logic             bsr_update,
    output logic             outputs_hiz,
    output logic             outputs_clamp,
    output logic             programming_mode_flag,
    output logic             read_protect,
    output logic             read_allow,
    output logic             verify_allow,
    output logic             program_allow,
    output logic             erase_allow,
    output logic             reconfig_trigger_out,
    output logic             reconfig_trigger_out_oe
);
    pjiu_tap_if tap ();

    pjiu_tap_fsm u_fsm (
        .tck    (tck),
        .resetn (resetn),
        .tms    (tms),
        .tap    (tap.ctrl)
    );

    // system clock side
    logic                             prot_q;
    logic                             prot_d;
    logic                             isp_q;
    logic                             rd_allow_q;
    logic                             vfy_allow_q;
    logic [pjiu_pkg::PULSE_CNT_W-1:0] pulse_cnt_q;
    logic [pjiu_pkg::PULSE_CNT_W-1:0] pulse_cnt_d;
    logic                             reload_tgl_s;
    logic                             reload_seen_q;
    logic                             reload_evt;
    logic                             reload_tgl_q;

    // protection is set by programming with the option, cleared by full erase
    // only; a set in the same cycle as an erase wins
    assign prot_d = protect_set | (prot_q & ~erase_all);

    // reload request toggle arriving from the test clock side
    pjiu_sync #(.W(1)) u_sync_reload (
        .clk    (clk_sys),
        .resetn (resetn),
        .d      (reload_tgl_q),
        .q      (reload_tgl_s)
    );

    assign reload_evt = reload_tgl_s ^ reload_seen_q;

    // one pulse per reload request, length fixed in system cycles
    assign pulse_cnt_d = reload_evt ? pjiu_pkg::PULSE_CNT_W'(pjiu_pkg::PULSE_CYC) :
                         (pulse_cnt_q != '0) ? pulse_cnt_q - 1'b1 : pulse_cnt_q;

    // protection, mode and access permissions
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            prot_q      <= 1'b0;
            isp_q       <= 1'b0;
            rd_allow_q  <= 1'b1;
            vfy_allow_q <= 1'b1;
        end else begin
            prot_q      <= prot_d;
            isp_q       <= isp_mode_in;
            rd_allow_q  <= ~prot_d;
            vfy_allow_q <= ~prot_d;
        end
    end

    // reconfiguration pulse generator
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pulse_cnt_q   <= '0;
            reload_seen_q <= 1'b0;
        end else begin
            pulse_cnt_q   <= pulse_cnt_d;
            reload_seen_q <= reload_tgl_s;
        end
    end

    assign read_protect          = prot_q;
    assign programming_mode_flag = isp_q;
    assign read_allow            = rd_allow_q;
    assign verify_allow          = vfy_allow_q;
    assign program_allow         = 1'b1;
    assign erase_allow           = 1'b1;

    // open-drain: drive low only while the pulse runs, else release
    assign reconfig_trigger_out    = 1'b0;
    assign reconfig_trigger_out_oe = (pulse_cnt_q != '0);

    // test clock side
    logic [1:0]                  stat_t;
    logic                        isp_t;
    logic                        prot_t;
    logic [pjiu_pkg::IR_W-1:0]   ir_sh_q;
    logic [pjiu_pkg::IR_W-1:0]   ir_sh_d;
    logic [pjiu_pkg::IR_W-1:0]   ir_q;
    logic [pjiu_pkg::IR_W-1:0]   cap_pat;
    logic [pjiu_pkg::DR_W-1:0]   dr_sh_q;
    logic [pjiu_pkg::DR_W-1:0]   dr_sh_d;
    logic [pjiu_pkg::DR_W-1:0]   dr_cap;
    logic                        tdo_q;
    logic                        tdo_oe_q;
    logic                        tdo_d;
    logic                        hiz_q;
    logic                        clamp_q;
    logic                        is_extest;
    logic                        is_sample;
    logic                        is_clamp;
    logic                        is_highz;
    logic                        is_idcode;
    logic                        is_usercode;
    logic                        is_bsr;
    logic                        is_bypass;
    logic                        new_reload;

    // mode and protection status into the test clock domain
    pjiu_sync #(.W(2)) u_sync_stat (
        .clk    (tck),
        .resetn (resetn),
        .d      ({isp_q, prot_q}),
        .q      (stat_t)
    );

    assign isp_t  = stat_t[1];
    assign prot_t = stat_t[0];

    // capture pattern: 000, mode, protection, 0, 01
    assign cap_pat = pjiu_pkg::CAP_FIXED
                   | (8'(isp_t)  << pjiu_pkg::CAP_ISP_BIT)
                   | (8'(prot_t) << pjiu_pkg::CAP_PROT_BIT);

    // instruction decode; unknown codes fall back to bypass
    assign is_extest   = (ir_q == pjiu_pkg::OP_EXTEST);
    assign is_sample   = (ir_q == pjiu_pkg::OP_SAMPLE);
    assign is_clamp    = (ir_q == pjiu_pkg::OP_CLAMP);
    assign is_highz    = (ir_q == pjiu_pkg::OP_HIGHZ);
    assign is_idcode   = (ir_q == pjiu_pkg::OP_IDCODE);
    assign is_usercode = (ir_q == pjiu_pkg::OP_USERCODE);
    assign is_bsr      = is_extest | is_sample;
    assign is_bypass   = ~(is_bsr | is_idcode | is_usercode);
    assign new_reload  = tap.update_ir & (ir_sh_q == pjiu_pkg::OP_RELOAD);

    // instruction shift register: capture, then shift least bit first
    assign ir_sh_d = tap.capture_ir ? cap_pat :
                     tap.shift_ir   ? {tdi, ir_sh_q[pjiu_pkg::IR_W-1:1]} :
                                      ir_sh_q;

    // data register capture: identity words or bypass zero
    assign dr_cap = is_idcode   ? ID_VALUE :
                    is_usercode ? usercode_val :
                                  '0;

    assign dr_sh_d = tap.capture_dr ? dr_cap :
                     !tap.shift_dr  ? dr_sh_q :
                     is_bypass      ? {{(pjiu_pkg::DR_W-1){1'b0}}, tdi} :
                                      {tdi, dr_sh_q[pjiu_pkg::DR_W-1:1]};

    // serial output source for the current scan
    assign tdo_d = tap.shift_ir ? ir_sh_q[0] :
                   is_bsr       ? bsr_tdo :
                                  dr_sh_q[0];

    // instruction and data shift registers, active instruction
    always_ff @(posedge tck or negedge resetn) begin
        if (!resetn) begin
            ir_sh_q <= pjiu_pkg::IR_RESET;
            ir_q    <= pjiu_pkg::IR_RESET;
            dr_sh_q <= '0;
        end else begin
            ir_sh_q <= ir_sh_d;
            dr_sh_q <= dr_sh_d;
            if (tap.tlr) begin
                ir_q <= pjiu_pkg::IR_RESET;
            end else if (tap.update_ir) begin
                ir_q <= ir_sh_q;
            end
        end
    end

    // reload toggle and registered pin controls
    always_ff @(posedge tck or negedge resetn) begin
        if (!resetn) begin
            reload_tgl_q <= 1'b0;
            hiz_q        <= 1'b0;
            clamp_q      <= 1'b0;
        end else begin
            reload_tgl_q <= reload_tgl_q ^ new_reload;
            hiz_q        <= is_highz | (isp_t & ~is_clamp);
            clamp_q      <= is_clamp | is_extest;
        end
    end

    // serial output changes on the falling test clock edge
    always_ff @(negedge tck or negedge resetn) begin
        if (!resetn) begin
            tdo_q    <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else begin
            tdo_q    <= tdo_d;
            tdo_oe_q <= tap.shift_ir | tap.shift_dr;
        end
    end

    assign tdo           = tdo_q;
    assign tdo_oe        = tdo_oe_q;
    assign outputs_hiz   = hiz_q;
    assign outputs_clamp = clamp_q;

    // boundary chain control passes through decoded tap states
    assign bsr_select  = is_bsr | is_clamp;
    assign bsr_capture = tap.capture_dr & is_bsr;
    assign bsr_shift   = tap.shift_dr & is_bsr;
    assign bsr_update  = tap.update_dr & is_bsr;
endmodule
`default_nettype wire

// [test/pjiu_host.sv]
/* test-port host model: makes the test clock only inside frames and drives
   mode select and serial in. assumes tdo settles after the falling test clock. */
`timescale 1ns/1ps
`default_nettype none
module pjiu_host (
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    // parked: clock low, pulled-up lines high
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end

    // one 15 ns test clock period; tdo taken at the rising edge
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #7.5 tck = 1'b1;
        o = tdo;
        #7.5 tck = 1'b0;
    endtask

    // n cycles in run-test/idle
    task automatic idle(input int n);
        logic o;
        for (int i = 0; i < n; i++) step(1'b0, 1'b1, o);
    endtask

    // five or more ones reach test-logic-reset, then idle
    task automatic reset_tap();
        logic o;
        for (int i = 0; i < 8; i++) step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
    endtask

    // scan n bits lsb first from idle on the ir or dr path, back to idle
    task automatic scan(input logic ir, input logic [31:0] din, input int n,
                        output logic [31:0] dout);
        logic o;
        dout = 32'h0;
        step(1'b1, 1'b1, o);
        if (ir) step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);  // capture
        step(1'b0, 1'b1, o);  // into shift
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, 1'b1, o);  // update
        step(1'b0, 1'b1, o);
    endtask
endmodule
`default_nettype wire

// [test/pjiu_top_chk.sv]
/* port assertions for the instruction unit: protection, status copy, tap
   exit behaviour and the reconfiguration pulse. assumes binding to pjiu_top. */
`timescale 1ns/1ps
`default_nettype none
module pjiu_top_chk (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdo_oe,
    input wire logic isp_mode_in,
    input wire logic protect_set,
    input wire logic erase_all,
    input wire logic bsr_select,
    input wire logic bsr_capture,
    input wire logic bsr_shift,
    input wire logic bsr_update,
    input wire logic outputs_clamp,
    input wire logic programming_mode_flag,
    input wire logic read_protect,
    input wire logic read_allow,
    input wire logic verify_allow,
    input wire logic program_allow,
    input wire logic erase_allow,
    input wire logic reconfig_trigger_out,
    input wire logic reconfig_trigger_out_oe
);
    logic [5:0] low_cnt_q;
    logic [5:0] low_cnt_d;

    // length of the running low pulse in system cycles
    assign low_cnt_d = reconfig_trigger_out_oe ? low_cnt_q + 6'h01 : 6'h00;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            low_cnt_q <= 6'h00;
        end else begin
            low_cnt_q <= low_cnt_d;
        end
    end

    // system clock domain
    AST_PULSE_MIN: assert property (@(posedge clk_sys) disable iff (!resetn)
        $fell(reconfig_trigger_out_oe) |-> low_cnt_q >= 6'h0c)
        else $error("reconfiguration pulse too short");
    AST_PULSE_MAX: assert property (@(posedge clk_sys) disable iff (!resetn)
        low_cnt_q <= 6'h14)
        else $error("reconfiguration pulse too long");
    AST_DRIVE_LOW: assert property (@(posedge clk_sys) disable iff (!resetn)
        reconfig_trigger_out_oe |-> !reconfig_trigger_out)
        else $error("reconfiguration output not driven low");
    AST_PROT_SET: assert property (@(posedge clk_sys) disable iff (!resetn)
        protect_set |=> read_protect)
        else $error("protection not set");
    AST_PROT_HOLD: assert property (@(posedge clk_sys) disable iff (!resetn)
        read_protect && !erase_all |=> read_protect)
        else $error("protection lost without erase");
    AST_PROT_CLR: assert property (@(posedge clk_sys) disable iff (!resetn)
        erase_all && !protect_set |=> !read_protect)
        else $error("protection kept after erase");
    AST_ALLOW: assert property (@(posedge clk_sys) disable iff (!resetn)
        read_allow == !read_protect && verify_allow == !read_protect
        && program_allow && erase_allow)
        else $error("access permissions wrong");
    AST_MODE_FLAG: assert property (@(posedge clk_sys) disable iff (!resetn)
        1'b1 |=> programming_mode_flag == $past(isp_mode_in))
        else $error("programming mode flag wrong");

    // test clock domain
    AST_SHIFT_EXIT: assert property (@(posedge tck) disable iff (!resetn)
        tms |=> !tdo_oe)
        else $error("serial output enabled outside shift");
    AST_TLR: assert property (@(posedge tck) disable iff (!resetn)
        tms [*8] |-> !bsr_select && !outputs_clamp)
        else $error("tap reset left a boundary instruction");
    AST_BSR_CTRL: assert property (@(posedge tck) disable iff (!resetn)
        bsr_capture || bsr_shift || bsr_update |-> bsr_select)
        else $error("boundary chain strobe without boundary instruction");

    COV_PULSE: cover property (@(posedge clk_sys) $rose(reconfig_trigger_out_oe));
    COV_ERASE: cover property (@(posedge clk_sys) $fell(read_protect));
    COV_CLAMP: cover property (@(posedge tck) $rose(outputs_clamp));
    COV_BSR_SHIFT: cover property (@(posedge tck) bsr_shift);
endmodule

bind pjiu_top pjiu_top_chk chk (.clk_sys, .resetn, .tck, .tms, .tdo_oe, .isp_mode_in,
    .protect_set, .erase_all, .bsr_select, .bsr_capture, .bsr_shift, .bsr_update,
    .outputs_clamp, .programming_mode_flag,
    .read_protect, .read_allow, .verify_allow, .program_allow, .erase_allow,
    .reconfig_trigger_out, .reconfig_trigger_out_oe);
`default_nettype wire

// [test/tb_pjiu_top.sv]
/* self-checking bench for the instruction unit: instruction table, status
   capture, protection and reload pulse. assumes the host model in pjiu_host. */
`timescale 1ns/1ps
`default_nettype none
module tb_pjiu_top;
    typedef struct {
        logic [7:0]  code;
        logic [2:0]  sel_clamp_hiz;
        int          len;
        logic [31:0] exp;
    } pjiu_row_t;
    localparam logic [31:0] ID_TB   = 32'h0c3a5e71;  // arbitrary identity value
    localparam logic [31:0] USER_TB = 32'h5aa5c33c;
    localparam int          LIMIT   = 6000;
    logic        clk_sys, resetn, isp_mode_in, protect_set, erase_all, bsr_tdo;
    logic        tck, tms, tdi, tdo, tdo_oe, bsr_select, outputs_hiz, outputs_clamp;
    logic        programming_mode_flag, read_protect, read_allow, verify_allow;
    logic        program_allow, erase_allow, reconfig_trigger_out, reconfig_trigger_out_oe;
    logic [31:0] usercode_val, got;
    wire         tdo_pin;
    logic        prev;
    int          n_fail, checks_done, cyc, hi, rises;
    pjiu_row_t   rows [8];

    pjiu_top #(.ID_VALUE(ID_TB)) uut (.clk_sys, .resetn, .tck, .tms, .tdi, .tdo, .tdo_oe,
        .usercode_val, .isp_mode_in, .protect_set, .erase_all, .bsr_tdo, .bsr_select,
        .bsr_capture(), .bsr_shift(), .bsr_update(), .outputs_hiz, .outputs_clamp,
        .programming_mode_flag, .read_protect, .read_allow, .verify_allow, .program_allow,
        .erase_allow, .reconfig_trigger_out, .reconfig_trigger_out_oe);
    pjiu_host host (.tck, .tms, .tdi, .tdo(tdo_pin));

    // serial output pin is pulled up while the design releases it
    assign tdo_pin = tdo_oe ? tdo : 1'b1;

    // system clock and hang guard
    always #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == LIMIT) begin
            n_fail++;
            test_done();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        checks_done++;
        if (g !== e) begin
            $display("wrong value at %0t: %s got %h want %h", $time, m, g, e);
            n_fail++;
        end
    endtask

    task automatic pulse(input logic s, input logic e);
        @(negedge clk_sys);
        protect_set = s;
        erase_all = e;
        @(negedge clk_sys);
        protect_set = 1'b0;
        erase_all = 1'b0;
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        resetn = 1'b0;  // host reset pulls output enable low
        isp_mode_in = 1'b0;
        protect_set = 1'b0;
        erase_all = 1'b0;
        bsr_tdo = 1'b1;
        usercode_val = USER_TB;
        rows[0] = '{pjiu_pkg::OP_EXTEST, 3'b110, 0, 32'h0};
        rows[1] = '{pjiu_pkg::OP_SAMPLE, 3'b100, 2, 32'h3};
        rows[2] = '{pjiu_pkg::OP_CLAMP, 3'b110, 0, 32'h0};
        rows[3] = '{pjiu_pkg::OP_HIGHZ, 3'b001, 0, 32'h0};
        rows[4] = '{pjiu_pkg::OP_USERCODE, 3'b000, 32, USER_TB};
        rows[5] = '{pjiu_pkg::OP_IDCODE, 3'b000, 32, ID_TB};
        rows[6] = '{pjiu_pkg::OP_BYPASS, 3'b000, 2, 32'h2};
        rows[7] = '{8'ha5, 3'b000, 2, 32'h2};
        repeat (12) @(negedge clk_sys);
        chk({25'h0, tdo_oe, read_protect, reconfig_trigger_out_oe, outputs_clamp,
             outputs_hiz, read_allow, verify_allow}, 32'h3, "in reset");
        resetn = 1'b1;
        host.idle(1);
        host.scan(1'b0, 32'h1, 32, got);
        chk(got, ID_TB, "id after reset");
        $display("reset test done");

        // instruction table: capture, decode and data path
        foreach (rows[i]) begin
            host.scan(1'b1, {24'h0, rows[i].code}, 8, got);
            chk(got, 32'h1, "capture");
            host.idle(2);
            chk({29'h0, bsr_select, outputs_clamp, outputs_hiz},
                {29'h0, rows[i].sel_clamp_hiz}, "decode");
            if (rows[i].len > 0) begin
                host.scan(1'b0, 32'h1, rows[i].len, got);
                chk(got, rows[i].exp, "data reg");
            end
        end
        $display("table test done");

        // protection and programming mode
        pulse(1'b1, 1'b0);
        chk({28'h0, read_protect, read_allow, verify_allow, program_allow & erase_allow},
            32'h9, "protect");
        isp_mode_in = 1'b1;
        host.idle(8);
        host.scan(1'b1, {24'h0, pjiu_pkg::OP_BYPASS}, 8, got);
        chk(got, 32'h19, "status capture");
        chk({31'h0, programming_mode_flag}, 32'h1, "mode flag");
        host.idle(2);
        chk({30'h0, outputs_clamp, outputs_hiz}, 32'h1, "isp float");
        host.scan(1'b1, {24'h0, pjiu_pkg::OP_CLAMP}, 8, got);
        host.idle(2);
        chk({30'h0, outputs_clamp, outputs_hiz}, 32'h2, "isp clamp");
        @(negedge clk_sys);
        isp_mode_in = 1'b0;
        pulse(1'b1, 1'b1);
        host.reset_tap();
        chk({31'h0, read_protect}, 32'h1, "kept");
        pulse(1'b0, 1'b1);
        chk({29'h0, read_protect, read_allow, verify_allow}, 32'h3, "erased");
        $display("protection test done");

        // reload twice: one pulse of twelve cycles each
        for (int k = 0; k < 2; k++) begin
            hi = 0;
            rises = 0;
            prev = 1'b0;
            fork
                host.scan(1'b1, {24'h0, pjiu_pkg::OP_RELOAD}, 8, got);
                repeat (80) @(negedge clk_sys) begin
                    hi += int'(reconfig_trigger_out_oe);
                    rises += int'(reconfig_trigger_out_oe && !prev);
                    prev = reconfig_trigger_out_oe;
                end
            join
            chk(hi, 32'd12, "pulse length");
            chk(rises, 32'd1, "pulse count");
            chk({31'h0, reconfig_trigger_out}, 32'h0, "low level");
        end
        $display("reload test done");
        test_done();
    end
endmodule
`default_nettype wire
